//--- vad_core.sv
// Voice activity detection core: energy, decision, tone and periodicity
`timescale 1ns/10ps

module vad_core
  import vad_pkg::*;
#(
  parameter int LAG_W = 8  // Lag width in bits
) (
  // Clock and reset
  input  wire logic                          sys_clk,
  input  wire logic                          sys_rst,
  // Frame analysis input from the encoder
  input  wire logic                          frame_valid,
  input  wire logic [vad_pkg::NCOEF*32-1:0]  acf_in,
  input  wire logic [vad_pkg::NRC*16-1:0]    reflection_coeffs,
  // Subframe lags after the frame is encoded
  input  wire logic                          lags_valid,
  input  wire logic [vad_pkg::NLAG*LAG_W-1:0] lags_in,
  // Adaptation loads from neighbouring logic
  input  wire logic                          rvad_load,
  input  wire logic [vad_pkg::NCOEF*16-1:0]  rvad_in,
  input  wire logic                          thvad_load,
  input  wire logic [15:0]                   thvad_exp_in,
  input  wire logic [15:0]                   thvad_mant_in,
  // Frame results
  output logic                               busy,
  output logic                               decision_valid,
  output logic                               vvad,
  output logic                               tone,
  output logic                               ptch_used,
  output logic                               below_energy_th,
  output logic [15:0]                        pvad_exp,
  output logic [15:0]                        pvad_mant,
  output logic [15:0]                        frame_energy_exp,
  output logic [15:0]                        frame_energy_mant,
  output logic [15:0]                        thvad_exp,
  output logic [15:0]                        thvad_mant,
  // Periodicity result
  output logic                               ptch,
  output logic                               ptch_valid
);
  import vad_pkg::*;

  // Refuse lag widths the lag compare cannot serve
  if (LAG_W < 8 || LAG_W > 14) begin : g_chk
    $error("vad_core: LAG_W out of range");
  end

  // Sequencer states
  typedef enum logic [3:0] {
    S_IDLE, S_MAC, S_NORM, S_STEP, S_A1SQ, S_POLE, S_PRED, S_DONE, S_PER
  } vad_state_t;

  // Complete module state, registered as one word
  typedef struct packed {
    vad_state_t               st;
    logic [3:0]               idx;        // Tap or step index
    logic                     ph;         // Sub-phase of error step
    logic [NCOEF-1:0][31:0]   acf;        // Latched autocorrelation
    logic [NRC-1:0][15:0]     rc;         // Latched reflection coeffs
    logic [NCOEF-1:0][15:0]   rvad;       // Adaptive predictor autocorr
    logic signed [53:0]       acc;        // Energy accumulator
    logic signed [15:0]       a1;         // First-order coefficient
    logic signed [31:0]       a1sq;       // a1 squared, Q30
    logic [31:0]              omr;        // One minus rc squared, Q15
    logic [15:0]              err;        // Prediction error, Q15
    logic [15:0]              th_e;       // Decision threshold exponent
    logic [15:0]              th_m;       // Decision threshold mantissa
    logic [15:0]              pv_e;
    logic [15:0]              pv_m;
    logic [15:0]              fe_e;
    logic [15:0]              fe_m;
    logic                     busy;
    logic                     dvalid;
    logic                     vvad;
    logic                     tone;
    logic                     ptch_prev;  // Flag frozen for this frame
    logic                     below;
    logic                     lag_pend;   // Lags waiting for idle
    logic [NLAG:0][LAG_W-1:0] lags;       // Entry 0 is last frame's lag 4
    logic [2:0]               lagcnt;
    logic [2:0]               oldcnt;
    logic [2:0]               voldcnt;
    logic                     ptch;
    logic                     pvalid;
  } vad_reg_t;

  // Constant reset image of the whole state
  localparam vad_reg_t RST_IMG = '{
    st: S_IDLE, idx: 4'h0, ph: 1'b0, acf: '0, rc: '0,
    rvad: {{(NCOEF-1)*16{1'b0}}, RVAD0_RST}, acc: '0, a1: '0, a1sq: '0,
    omr: '0, err: ERR_INIT, th_e: E_THVAD_RST, th_m: M_THVAD_RST,
    pv_e: '0, pv_m: '0, fe_e: '0, fe_m: '0, busy: 1'b0, dvalid: 1'b0,
    vvad: 1'b0, tone: 1'b0, ptch_prev: PTCH_RST, below: 1'b0,
    lag_pend: 1'b0, lags: {{NLAG*LAG_W{1'b0}}, LAG_W'(LAG0_RST)},
    lagcnt: '0, oldcnt: '0, voldcnt: '0, ptch: PTCH_RST, pvalid: 1'b0};

  vad_reg_t s_r;    // Current state
  vad_reg_t s_nxt;  // Next state

  // Normalise a non-negative integer into exponent and mantissa
  function automatic logic [31:0] pf_norm(input logic [53:0] v);
    logic [5:0]  p;
    logic        pow2;
    logic [53:0] sh;
    p    = 6'd0;
    pow2 = 1'b0;
    sh   = '0;
    for (int k = 0; k < 54; k++) begin
      if (v[k]) begin
        p = 6'(k);
      end
    end
    pow2 = ((v & (v - 54'd1)) == '0);
    if (v == '0) begin
      pf_norm = '0;                                     // Zero carries no scale
    end else if (pow2) begin
      pf_norm = {10'h000, p, MANT_POW2};
    end else begin
      sh      = (p >= 6'd14) ? (v >> (p - 6'd14)) : (v << (6'd14 - p));
      pf_norm = {10'h000, 6'(p + 6'd1), 1'b0, sh[14:0]};
    end
  endfunction : pf_norm

  // Greater-than between two pseudo-floats
  function automatic logic pf_gt(input logic [15:0] ea, input logic [15:0] ma,
                                 input logic [15:0] eb, input logic [15:0] mb);
    if (ea != eb) begin
      pf_gt = (ea > eb);
    end else begin
      pf_gt = (ma > mb);
    end
  endfunction : pf_gt

  // Lag pair periodic when larger is near 1, 2 or 3 times smaller
  function automatic logic lag_match(input logic [LAG_W-1:0] x,
                                     input logic [LAG_W-1:0] y);
    logic [LAG_W+1:0] lo;
    logic [LAG_W+1:0] hi;
    logic [LAG_W+1:0] m;
    logic [LAG_W+1:0] d;
    lo        = (x < y) ? {2'b00, x} : {2'b00, y};
    hi        = (x < y) ? {2'b00, y} : {2'b00, x};
    m         = '0;
    d         = '0;
    lag_match = 1'b0;
    for (int k = 1; k <= 3; k++) begin
      m = lo * (LAG_W + 2)'(k);
      d = (hi > m) ? (hi - m) : (m - hi);
      if (d < (LAG_W + 2)'(LTHRESH)) begin
        lag_match = 1'b1;
      end
    end
  endfunction : lag_match

  // Single shared signed multiplier and its operand select
  logic signed [32:0] mul_a;     // One bit wider: energy word is unsigned
  logic signed [15:0] mul_b;
  logic signed [47:0] mul_p;
  logic signed [34:0] im4;       // 4*a2 - a1^2 in Q30
  logic [31:0]        pv_pf;     // Normalised filtered energy
  logic [31:0]        fe_pf;     // Normalised frame energy

  // Operand routing; one product per cycle keeps the datapath small
  always_comb begin
    mul_a = '0;
    mul_b = '0;
    case (s_r.st)
      S_MAC: begin
        // Energy word is unsigned, the other lags signed
        mul_a = (s_r.idx == 4'h0) ? $signed({1'b0, s_r.acf[0]})
                                  : 33'(signed'(s_r.acf[s_r.idx]));
        mul_b = $signed(s_r.rvad[s_r.idx]);
      end
      S_STEP: begin
        mul_a = 33'(signed'(s_r.rc[0]));
        mul_b = $signed(s_r.rc[1]);
      end
      S_A1SQ: begin
        mul_a = 33'(s_r.a1);
        mul_b = s_r.a1;
      end
      S_POLE: begin
        mul_a = 33'(s_r.a1sq);
        mul_b = $signed(FREQTH_Q15);
      end
      S_PRED: begin
        mul_a = s_r.ph ? 33'($signed(s_r.omr)) : 33'(signed'(s_r.rc[s_r.idx[1:0]]));
        mul_b = s_r.ph ? $signed(s_r.err) : $signed(s_r.rc[s_r.idx[1:0]]);
      end
      default: begin
        mul_a = '0;
        mul_b = '0;
      end
    endcase
  end

  assign mul_p = mul_a * mul_b;
  assign im4   = (35'(s_r.rc[1] == 16'h0 ? 35'sd0 : 35'(signed'(s_r.rc[1]))) <<< 17)
                 - 35'(s_r.a1sq);
  // Negative energy sums are clamped to zero before normalising
  assign pv_pf = pf_norm(s_r.acc[53] ? 54'd0 : 54'(s_r.acc));
  assign fe_pf = pf_norm(54'(s_r.acf[0]));

  // Next-state logic for the whole core
  always_comb begin
    s_nxt        = s_r;
    s_nxt.dvalid = 1'b0;
    s_nxt.pvalid = 1'b0;
    // Lags latched at once, processed when idle
    if (lags_valid) begin
      s_nxt.lags[NLAG:1] = lags_in;
      s_nxt.lag_pend     = 1'b1;
    end
    // Adaptation loads only touch state between frames
    if (rvad_load && s_r.st == S_IDLE) begin
      s_nxt.rvad = rvad_in;
    end
    if (thvad_load && s_r.st == S_IDLE) begin
      s_nxt.th_e = thvad_exp_in;
      s_nxt.th_m = thvad_mant_in;
    end
    case (s_r.st)
      S_IDLE: begin
        if (s_r.lag_pend) begin
          s_nxt.st     = S_PER;
          s_nxt.idx    = 4'h1;
          s_nxt.lagcnt = '0;
          s_nxt.busy   = 1'b1;
        end else if (frame_valid) begin
          s_nxt.acf       = acf_in;
          s_nxt.rc        = reflection_coeffs;
          s_nxt.ptch_prev = s_r.ptch;
          s_nxt.acc       = '0;
          s_nxt.idx       = 4'h0;
          s_nxt.busy      = 1'b1;
          s_nxt.st        = S_MAC;
        end
      end
      // Energy sum over the nine lags of the frame autocorrelation
      S_MAC: begin
        if (s_r.idx == 4'h0) begin
          s_nxt.acc = s_r.acc + 54'(mul_p);
        end else begin
          s_nxt.acc = s_r.acc + (54'(mul_p) <<< 1);
        end
        s_nxt.idx = s_r.idx + 4'h1;
        if (s_r.idx == 4'(NCOEF - 1)) begin
          s_nxt.st = S_NORM;
        end
      end
      // Pseudo-float conversion and primary decision
      S_NORM: begin
        s_nxt.pv_e  = pv_pf[31:16];
        s_nxt.pv_m  = pv_pf[15:0];
        s_nxt.fe_e  = fe_pf[31:16];
        s_nxt.fe_m  = fe_pf[15:0];
        s_nxt.vvad  = pf_gt(pv_pf[31:16], pv_pf[15:0], s_r.th_e, s_r.th_m);
        s_nxt.below = pf_gt(E_ENERGY_TH, M_ENERGY_TH, fe_pf[31:16], fe_pf[15:0]);
        // Quiet frame pulls the threshold down to its floor
        if (pf_gt(E_ENERGY_TH, M_ENERGY_TH, fe_pf[31:16], fe_pf[15:0])) begin
          s_nxt.th_e = E_TH_FLOOR;
          s_nxt.th_m = M_TH_FLOOR;
        end
        s_nxt.st = S_STEP;
      end
      // Step-up: a1 = rc1 + rc1*rc2, a2 = rc2, a0 = 1
      S_STEP: begin
        if (32'(signed'(s_r.rc[0])) + 32'(mul_p >>> 15) > 32'sd32767) begin
          s_nxt.a1 = 16'sh7fff;
        end else if (32'(signed'(s_r.rc[0])) + 32'(mul_p >>> 15) < -32'sd32768) begin
          s_nxt.a1 = -16'sh8000;
        end else begin
          s_nxt.a1 = 16'($signed(s_r.rc[0]) + 32'(mul_p >>> 15));
        end
        s_nxt.st = S_A1SQ;
      end
      S_A1SQ: begin
        s_nxt.a1sq = 32'(mul_p);
        s_nxt.st   = S_POLE;
      end
      // Pole position tests ahead of the prediction error test
      S_POLE: begin
        s_nxt.err = ERR_INIT;
        s_nxt.idx = 4'h0;
        s_nxt.ph  = 1'b0;
        if (im4 < 0) begin
          s_nxt.tone = 1'b0;
          s_nxt.st   = S_DONE;
        end else if (s_r.a1 > 0) begin
          s_nxt.st = S_PRED;
        end else if ((50'(im4) <<< 15) < 50'(mul_p)) begin
          s_nxt.tone = 1'b0;
          s_nxt.st   = S_DONE;
        end else begin
          s_nxt.st = S_PRED;
        end
      end
      // Error = product of (1 - rc^2) over four stages
      S_PRED: begin
        s_nxt.ph = ~s_r.ph;
        if (!s_r.ph) begin
          s_nxt.omr = ONE_Q15 - 32'(mul_p >>> 15);
        end else begin
          s_nxt.err = 16'(mul_p >>> 15);
          s_nxt.idx = s_r.idx + 4'h1;
          if (s_r.idx == 4'(NRC - 1)) begin
            s_nxt.tone = (16'(mul_p >>> 15) < PREDTH_Q15);
            s_nxt.st   = S_DONE;
          end
        end
      end
      S_DONE: begin
        s_nxt.dvalid = 1'b1;
        s_nxt.busy   = 1'b0;
        s_nxt.st     = S_IDLE;
      end
      // Compare consecutive lags, lag 0 being the previous frame's last
      S_PER: begin
        s_nxt.lagcnt = s_r.lagcnt
                       + 3'(lag_match(s_r.lags[s_r.idx - 4'h1], s_r.lags[s_r.idx]));
        s_nxt.idx = s_r.idx + 4'h1;
        if (s_r.idx == 4'(NLAG)) begin
          s_nxt.ptch     = ({1'b0, s_r.oldcnt} + {1'b0, s_nxt.lagcnt}) >= NTHRESH;
          s_nxt.voldcnt  = s_r.oldcnt;
          s_nxt.oldcnt   = s_nxt.lagcnt;
          s_nxt.lags[0]  = s_r.lags[NLAG];
          s_nxt.lag_pend = lags_valid;
          s_nxt.pvalid   = 1'b1;
          s_nxt.busy     = 1'b0;
          s_nxt.st       = S_IDLE;
        end
      end
      default: s_nxt.st = S_IDLE;
    endcase
  end

  // State register; reset loads the constant initial image
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      s_r <= RST_IMG;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs straight from the state register
  assign busy              = s_r.busy;
  assign decision_valid    = s_r.dvalid;
  assign vvad              = s_r.vvad;
  assign tone              = s_r.tone;
  assign ptch_used         = s_r.ptch_prev;
  assign below_energy_th   = s_r.below;
  assign pvad_exp          = s_r.pv_e;
  assign pvad_mant         = s_r.pv_m;
  assign frame_energy_exp  = s_r.fe_e;
  assign frame_energy_mant = s_r.fe_m;
  assign thvad_exp         = s_r.th_e;
  assign thvad_mant        = s_r.th_m;
  assign ptch              = s_r.ptch;
  assign ptch_valid        = s_r.pvalid;

  // Checks beside the logic
  a_reset_init: assert property (@(posedge sys_clk) $fell(sys_rst) |->
    (s_r.ptch && s_r.th_e == E_THVAD_RST && s_r.lags[0] == LAG_W'(LAG0_RST)))
    else $error("state not at initial values after reset");
  a_start_cond: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_r.st == S_IDLE && s_nxt.st == S_MAC) |-> frame_valid)
    else $error("frame started without inputs");
  a_prev_ptch: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_r.st == S_IDLE && frame_valid && !s_r.lag_pend) |=> ptch_used == $past(ptch))
    else $error("decision not using previous periodicity");
  a_per_idle: assert property (@(posedge sys_clk) disable iff (sys_rst)
    ptch_valid |-> $past(s_r.st, 1) == S_PER && !busy)
    else $error("periodicity update outside its slot");
  a_mant_norm: assert property (@(posedge sys_clk) disable iff (sys_rst)
    decision_valid && pvad_exp != 16'h0 |-> pvad_mant >= MANT_MIN)
    else $error("pvad mantissa not normalised");
  a_vvad_dec: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_r.st == S_NORM |=> vvad == ((pvad_exp > $past(s_r.th_e)) ||
      (pvad_exp == $past(s_r.th_e) && pvad_mant > $past(s_r.th_m))))
    else $error("primary decision mismatch");
  a_floor_load: assert property (@(posedge sys_clk) disable iff (sys_rst)
    s_r.st == S_NORM ##1 below_energy_th |-> thvad_exp == E_TH_FLOOR && thvad_mant == M_TH_FLOOR)
    else $error("threshold floor not applied");
  a_im_neg: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_r.st == S_POLE && im4 < 0) |=> !s_r.tone ##1 decision_valid)
    else $error("negative im not rejected");
  a_frame_len: assert property (@(posedge sys_clk) disable iff (sys_rst)
    (s_r.st == S_IDLE && s_nxt.st == S_MAC) |-> ##[15:23] decision_valid)
    else $error("frame computation length out of range");
  c_tone:  cover property (@(posedge sys_clk) decision_valid && tone);
  c_voice: cover property (@(posedge sys_clk) decision_valid && vvad);
  c_ptch:  cover property (@(posedge sys_clk) ptch_valid && ptch);
endmodule : vad_core

//--- vad_core_tb.sv
// Self-checking bench for the voice activity detection core
`timescale 1ns/10ps
module vad_core_tb;
  import vad_pkg::*;
  // Expected frame result: energy, {below, tone, ptch used}, threshold
  typedef struct packed {
    logic [31:0] fe;
    logic [2:0]  flags;
    logic        chk;
    logic [31:0] th;
  } vad_note_t;
  // Tone table: {rc4, rc3, rc2, rc1} and the tone expected
  localparam logic [63:0] RCS [5] = '{64'h7333_7333_c000_4000, 64'h7333_7333_4000_4000,
    64'h0000_0000_4000_4000, 64'h7333_7333_2148_8ccd, 64'h7333_7333_4000_c000};
  localparam logic [4:0]  TNS = 5'b10010;
  localparam logic [31:0] LGS [4] = '{32'h2828_2828, 32'h2828_2828, 32'h2828_2828,
    32'h6128_6128};
  logic           sys_clk = 1'b0;
  logic           sys_rst = 1'b1;
  logic           rvad_load = 1'b0;
  logic [143:0]   rvad_in = 144'h6;
  logic           thvad_load = 1'b0;
  logic [31:0]    th_in = 32'h0;
  logic           frame_valid, lags_valid;
  logic [287:0]   acf_in;
  logic [63:0]    reflection_coeffs;
  logic [31:0]    lags_in;
  logic           busy, decision_valid, vvad, tone, ptch_used, below_energy_th;
  logic           ptch, ptch_valid;
  logic [15:0]    pvad_exp, pvad_mant, frame_energy_exp, frame_energy_mant;
  logic [15:0]    thvad_exp, thvad_mant;
  int             err_total = 0;
  int             comparisons = 0;
  vad_note_t      fq [$];       // Pending frame results
  logic           pq [$];       // Pending periodicity results
  logic           ptch_exp = PTCH_RST;
  int             prev_cnt = 0;
  logic [7:0]     lag_last = LAG0_RST;
  logic [31:0]    th_cur = {E_THVAD_RST, M_THVAD_RST};

  // 100 MHz clock
  always #5 sys_clk = ~sys_clk;

  vad_core #(.LAG_W(8)) vad_core_inst (.sys_clk, .sys_rst, .frame_valid, .acf_in,
    .reflection_coeffs, .lags_valid, .lags_in, .rvad_load, .rvad_in, .thvad_load,
    .thvad_exp_in(th_in[31:16]), .thvad_mant_in(th_in[15:0]), .busy, .decision_valid,
    .vvad, .tone, .ptch_used, .below_energy_th, .pvad_exp, .pvad_mant, .frame_energy_exp,
    .frame_energy_mant, .thvad_exp, .thvad_mant, .ptch, .ptch_valid);
  vad_enc_model #(.LAG_W(8)) vad_enc_model_inst (.sys_clk, .frame_valid, .acf_in,
    .reflection_coeffs, .lags_valid, .lags_in);

  task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : cmp_word

  task automatic cmp_flag(input string nm, input logic e, input logic g);
    comparisons++;
    if (g !== e) begin
      err_total++;
      $display("wrong value %s expected %b seen %b", nm, e, g);
    end
  endtask : cmp_flag

  task automatic close_out();
    $display("comparisons %0d, mismatches %0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : close_out

  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tick

  // Bounded wait for a result strobe; a run-out ends the run
  task automatic wait_hi(input logic lagside, output int n);
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
      if (n == 2) cmp_flag("busy high", 1'b1, busy);
    end while ((lagside ? ptch_valid : decision_valid) !== 1'b1 && n < 40);
    cmp_flag("busy low", 1'b0, busy);
    if (n >= 40) begin
      err_total++;
      close_out();
    end
  endtask : wait_hi

  // Smallest covering power, mantissa scaled to 32768
  function automatic logic [31:0] pf_of(input logic [31:0] v);
    logic [47:0] w;
    logic [15:0] e;
    e = 16'h0;
    while (e < 32 && (48'h1 << e) < v) e++;
    w = ({16'h0, v} << 15) >> e;
    return (v == 0) ? 32'h0 : {e, w[15:0]};
  endfunction : pf_of

  // Exponent decides first, mantissa on a tie
  function automatic logic pf_gt(input logic [31:0] a, input logic [31:0] b);
    return ($signed(a[31:16]) > $signed(b[31:16])) ||
      (a[31:16] == b[31:16] && a[15:0] > b[15:0]);
  endfunction : pf_gt

  // Energy well above the pth level, exact in pseudo-float
  function automatic logic [31:0] rnd_e();
    return (($urandom() % 32000) + 2) << 17;
  endfunction : rnd_e

  task automatic load_th(input logic [31:0] t);
    @(posedge sys_clk);
    thvad_load <= 1'b1;
    th_in      <= t;
    @(posedge sys_clk);
    thvad_load <= 1'b0;
    th_cur = t;
    tick(1);
    cmp_word("thvad load", t, {thvad_exp, thvad_mant});
  endtask : load_th

  task automatic load_r(input logic [15:0] r0);
    @(posedge sys_clk);
    rvad_load <= 1'b1;
    rvad_in   <= {128'h0, r0};
    @(posedge sys_clk);
    rvad_load <= 1'b0;
  endtask : load_r

  // One frame; dup repeats the strobe while busy, which must be ignored
  task automatic frame(input logic [31:0] e0, input logic [63:0] rc, input logic tn,
                       input logic dup);
    logic [287:0] a;
    vad_note_t    n;
    int           lat;
    for (int i = 1; i < 9; i++) a[32*i +: 32] = $urandom();
    a[31:0] = e0;
    n.fe    = pf_of(e0);
    n.flags = {e0 < 32'd210000, tn, ptch_exp};
    n.chk   = (e0 >= 32'd210000);
    n.th    = th_cur;
    fq.push_back(n);
    vad_enc_model_inst.present_frame(a, rc);
    if (dup) vad_enc_model_inst.present_frame(~a, rc);
    wait_hi(1'b0, lat);
    cmp_flag("latency", 1'b1, lat >= 12 && lat <= 24);
    if (e0 < 32'd210000) th_cur = {E_TH_FLOOR, M_TH_FLOOR};
    tick(1);
    cmp_word("thvad", th_cur, {thvad_exp, thvad_mant});
  endtask : frame

  // Lag update with the expected periodicity worked out here
  task automatic lag_upd(input logic [31:0] l);
    int         c, lat;
    logic [7:0] p, q, hi, lo;
    logic       hit;
    c = 0;
    p = lag_last;
    for (int i = 0; i < 4; i++) begin
      q   = l[8*i +: 8];
      hi  = (p > q) ? p : q;
      lo  = (p > q) ? q : p;
      hit = 1'b0;
      for (int k = 1; k < 4; k++) hit |= (int'(hi) - k * int'(lo)) inside {[-1:1]};
      c += hit;
      p = q;
    end
    ptch_exp = (prev_cnt + c) >= 7;
    prev_cnt = c;
    lag_last = l[31:24];
    pq.push_back(ptch_exp);
    vad_enc_model_inst.present_lags(l);
    wait_hi(1'b1, lat);
    tick(1);
  endtask : lag_upd

  // Result watcher: oldest note against each strobe
  always @(posedge sys_clk) begin
    vad_note_t n;
    if (decision_valid === 1'b1) begin
      if (fq.size() == 0) cmp_flag("spare decision", 1'b0, 1'b1);
      else begin
        n = fq.pop_front();
        cmp_word("frame energy", n.fe, {frame_energy_exp, frame_energy_mant});
        cmp_flag("below", n.flags[2], below_energy_th);
        cmp_flag("tone", n.flags[1], tone);
        cmp_flag("ptch_used", n.flags[0], ptch_used);
        cmp_flag("pvad norm", 1'b1, pvad_mant >= MANT_MIN || pvad_exp == 16'h0);
        if (n.chk) cmp_flag("vvad", pf_gt({pvad_exp, pvad_mant}, n.th), vvad);
      end
    end
    if (ptch_valid === 1'b1) begin
      if (pq.size() == 0) cmp_flag("spare ptch", 1'b0, 1'b1);
      else cmp_flag("ptch", pq.pop_front(), ptch);
    end
  end

  // Main sequence
  initial begin
    logic [31:0] pv;
    void'($urandom(9021));
    tick(20);
    sys_rst <= 1'b0;
    tick(1);
    cmp_word("thvad reset", {E_THVAD_RST, M_THVAD_RST}, {thvad_exp, thvad_mant});
    cmp_flag("ptch reset", PTCH_RST, ptch);
    cmp_flag("ptch_used reset", PTCH_RST, ptch_used);
    $display("test reset done");
    load_r(RVAD0_RST);
    for (int i = 0; i < 5; i++) frame(rnd_e(), RCS[i], TNS[i], 1'b0);
    $display("test tone done");
    frame(32'h2_0000, RCS[2], 1'b0, 1'b0);
    frame(32'h4_0000, RCS[2], 1'b0, 1'b0);
    for (int i = 0; i < 6; i++) frame(($urandom() % 6) << 17, RCS[2], 1'b0, 1'b0);
    $display("test energy done");
    frame(32'h0100_0000, RCS[2], 1'b0, 1'b0);
    pv = 32'h001b_6000;
    cmp_word("pvad", pv, {pvad_exp, pvad_mant});
    foreach (LGS[i]) begin
      load_th(pv + ((i < 2) ? 32'(i) - 32'd1 : (32'(2 * i) - 32'd5) << 16));
      frame(32'h0100_0000, RCS[2], 1'b0, 1'b0);
    end
    load_r(16'h000c);
    frame(32'h0100_0000, RCS[2], 1'b0, 1'b0);
    cmp_word("pvad doubled", pv + 32'h0001_0000, {pvad_exp, pvad_mant});
    load_r(RVAD0_RST);
    $display("test decision done");
    frame(rnd_e(), RCS[1], 1'b1, 1'b1);
    tick(30);
    $display("test refusal done");
    for (int i = 0; i < 5; i++) begin
      lag_upd((i < 4) ? LGS[i] : ($urandom() | 32'h1010_1010));
      frame(rnd_e(), RCS[i], TNS[i], 1'b0);
    end
    $display("test periodicity done");
    tick(30);
    close_out();
  end

  // Overall limit on the run
  initial begin
    repeat (100000) @(posedge sys_clk);
    err_total++;
    close_out();
  end
endmodule : vad_core_tb

//--- vad_enc_model.sv
// Speech encoder stand-in: frame analysis words and subframe lags
`timescale 1ns/10ps
module vad_enc_model
  import vad_pkg::*;
#(
  parameter int LAG_W = 8  // Lag width in bits
) (
  // Clock
  input  wire logic                          sys_clk,
  // Frame analysis, all words in one cycle
  output logic                               frame_valid,
  output logic [vad_pkg::NCOEF*32-1:0]       acf_in,
  output logic [vad_pkg::NRC*16-1:0]         reflection_coeffs,
  // Lags of the frame just encoded
  output logic                               lags_valid,
  output logic [vad_pkg::NLAG*LAG_W-1:0]     lags_in
);
  // Quiet until the first request
  initial begin
    frame_valid       <= 1'b0;
    acf_in            <= '0;
    reflection_coeffs <= '0;
    lags_valid        <= 1'b0;
    lags_in           <= '0;
  end

  // Whole analysis set under one strobe; bus scrambled once released
  task automatic present_frame(input logic [NCOEF*32-1:0] a, input logic [NRC*16-1:0] r);
    @(posedge sys_clk);
    frame_valid       <= 1'b1;
    acf_in            <= a;
    reflection_coeffs <= r;
    @(posedge sys_clk);
    frame_valid       <= 1'b0;
    acf_in            <= ~a;
    reflection_coeffs <= ~r;
  endtask : present_frame

  // Lags only once the frame has been encoded, so caller waits first
  task automatic present_lags(input logic [NLAG*LAG_W-1:0] l);
    @(posedge sys_clk);
    lags_valid <= 1'b1;
    lags_in    <= l;
    @(posedge sys_clk);
    lags_valid <= 1'b0;
    lags_in    <= ~l;
  endtask : present_lags
endmodule : vad_enc_model

//--- vad_pkg.sv
// Constants shared by the voice activity detection core
package vad_pkg;
  // Pseudo-float and autocorrelation widths, coefficient and lag counts
  localparam int          PF_W          = 16;
  localparam int          ACF_W         = 32;
  localparam int          NCOEF         = 9;
  localparam int          NRC           = 4;
  localparam int          NLAG          = 4;
  // Energy threshold, threshold margin, lower threshold limit
  localparam logic [15:0] E_ENERGY_TH   = 16'h0012;
  localparam logic [15:0] M_ENERGY_TH   = 16'h668a;
  localparam logic [15:0] E_TH_MARGIN   = 16'h001b;
  localparam logic [15:0] M_TH_MARGIN   = 16'h6acf;
  localparam logic [15:0] E_TH_FLOOR    = 16'h0014;
  localparam logic [15:0] M_TH_FLOOR    = 16'h445c;
  // Decision threshold reset value (1400000)
  localparam logic [15:0] E_THVAD_RST   = 16'h0015;
  localparam logic [15:0] M_THVAD_RST   = 16'h5573;
  // Adaptive predictor autocorrelation reset: first tap 6, rest zero
  localparam logic [15:0] RVAD0_RST     = 16'h0006;
  // Mantissa normalisation bounds
  localparam logic [15:0] MANT_MIN      = 16'h4000;
  localparam logic [15:0] MANT_POW2     = 16'h8000;
  // Tone tests in Q15: 0.0973 and 0.0447 (strict less-than)
  localparam logic [15:0] FREQTH_Q15    = 16'h0c74;
  localparam logic [15:0] PREDTH_Q15    = 16'h05b9;
  localparam logic [31:0] ONE_Q15       = 32'h0000_8000;
  localparam logic [15:0] ERR_INIT      = 16'h7fff;
  // Periodicity detection
  localparam logic [7:0]  LAG0_RST      = 8'h15;
  localparam logic [7:0]  LTHRESH       = 8'h02;
  localparam logic [3:0]  NTHRESH       = 4'h7;
  localparam logic        PTCH_RST      = 1'b1;
endpackage : vad_pkg
